// >>> verilog/cbsc_top.sv
/*
 * SMBus byte read/write slave holding the control bytes of a clock
 * fan-out buffer, oversampling the bus on the reference clock.
 * Assumes i_ref_clk runs far faster than the bus clock and that an
 * outside open-drain pad combines o_sda_out with o_sda_oe_n.
 */
`timescale 1ns/1ps
`include "cbsc_cfg.svh"

module cbsc_top
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_pair_one_enable,
    input wire logic i_pair_six_enable,
    output cbsc_pkg::cbsc_mode_t o_mode,
    output logic [3:0] o_pair_enable,
    output logic [3:0] o_stop_enable,
    output logic o_sda_out,
    output logic o_sda_oe_n
);
    import cbsc_pkg::*;

    function automatic logic [7:0] merge_byte(input logic [7:0] data,
                                              input logic [7:0] mask,
                                              input logic [7:0] rst);
        merge_byte = (data & mask) | (rst & ~mask);
    endfunction

    function automatic logic [3:0] pair_bits(input logic [7:0] data);
        pair_bits = {data[`CBSC_PAIR_SIX], data[`CBSC_PAIR_FIVE],
                     data[`CBSC_PAIR_TWO], data[`CBSC_PAIR_ONE]};
    endfunction

    logic scl_meta_ff;
    logic scl_sync_ff;
    logic scl_prev_ff;
    logic sda_meta_ff;
    logic sda_sync_ff;
    logic sda_prev_ff;
    logic [1:0] pin_meta_ff;
    logic [1:0] pin_sync_ff;

    cbsc_state_t state_ff;
    cbsc_state_t nxt_state;
    cbsc_state_t ack_next_ff;
    cbsc_state_t nxt_ack_next;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [7:0] rx_ff;
    logic [7:0] nxt_rx;
    logic [7:0] tx_ff;
    logic [7:0] nxt_tx;
    logic [6:0] offset_ff;
    logic [6:0] nxt_offset;
    logic cmd_ok_ff;
    logic nxt_cmd_ok;
    logic sda_oe_n_ff;
    logic nxt_sda_oe_n;
    logic wr_en;

    logic [7:0] mode_ff;
    logic [7:0] pair_ff;
    logic [7:0] stop_ff;
    logic [7:0] rd_data;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    cbsc_mode_t mode_out_ff;
    logic [3:0] pair_out_ff;
    logic [3:0] stop_out_ff;
    logic sda_out_ff;

    // Two-stage synchronisers, then a history stage for edges
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            scl_meta_ff <= 1'b1;
            scl_sync_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_sync_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
            pin_meta_ff <= 2'h3;
            pin_sync_ff <= 2'h3;
        end
        else
        begin
            scl_meta_ff <= i_scl;
            scl_sync_ff <= scl_meta_ff;
            scl_prev_ff <= scl_sync_ff;
            sda_meta_ff <= i_sda;
            sda_sync_ff <= sda_meta_ff;
            sda_prev_ff <= sda_sync_ff;
            pin_meta_ff <= {i_pair_six_enable, i_pair_one_enable};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign scl_rise = scl_sync_ff & ~scl_prev_ff;
    assign scl_fall = ~scl_sync_ff & scl_prev_ff;
    assign bus_start = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
    assign bus_stop = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        unique case (offset_ff)
            `CBSC_OFS_MODE: rd_data = mode_ff;
            `CBSC_OFS_PAIR: rd_data = pair_ff;
            `CBSC_OFS_STOP: rd_data = stop_ff;
            default: rd_data = 8'h00;
        endcase
    end

    // Bus sequencer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_ack_next = ack_next_ff;
        nxt_cnt = cnt_ff;
        nxt_rx = rx_ff;
        nxt_tx = tx_ff;
        nxt_offset = offset_ff;
        nxt_cmd_ok = cmd_ok_ff;
        nxt_sda_oe_n = sda_oe_n_ff;
        wr_en = 1'b0;
        if (bus_stop)
        begin
            nxt_state = CBSC_IDLE;
            nxt_cmd_ok = 1'b0;
            nxt_sda_oe_n = 1'b1;
        end
        else if (bus_start)
        begin
            nxt_state = CBSC_ADDR;
            nxt_cnt = 4'h0;
            nxt_sda_oe_n = 1'b1;
        end
        else
        begin
            unique case (state_ff)
                CBSC_IDLE, CBSC_WAIT:
                begin
                    nxt_sda_oe_n = 1'b1;
                end
                CBSC_ADDR, CBSC_CMD, CBSC_WDATA:
                begin
                    if (scl_rise)
                    begin
                        nxt_rx = {rx_ff[6:0], sda_sync_ff};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    else if (scl_fall && cnt_ff == `CBSC_BIT_LAST)
                    begin
                        nxt_state = CBSC_WAIT;
                        if (state_ff == CBSC_ADDR)
                        begin
                            if (rx_ff[7:1] == `CBSC_SLAVE_ADDR7)
                            begin
                                if (!rx_ff[0])
                                begin
                                    nxt_state = CBSC_ACK;
                                    nxt_ack_next = CBSC_CMD;
                                end
                                else if (cmd_ok_ff)
                                begin
                                    nxt_state = CBSC_ACK;
                                    nxt_ack_next = CBSC_RDATA;
                                    nxt_tx = rd_data;
                                end
                            end
                        end
                        else if (state_ff == CBSC_CMD)
                        begin
                            if (rx_ff[`CBSC_CMD_BYTE_BIT])
                            begin
                                nxt_state = CBSC_ACK;
                                nxt_ack_next = CBSC_WDATA;
                                nxt_offset = rx_ff[6:0];
                                nxt_cmd_ok = 1'b1;
                            end
                        end
                        else
                        begin
                            nxt_state = CBSC_ACK;
                            nxt_ack_next = CBSC_WAIT;
                            wr_en = 1'b1;
                        end
                        nxt_sda_oe_n = (nxt_state != CBSC_ACK);
                    end
                end
                CBSC_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_state = ack_next_ff;
                        nxt_cnt = 4'h0;
                        nxt_rx = 8'h00;
                        if (ack_next_ff == CBSC_RDATA)
                        begin
                            nxt_sda_oe_n = tx_ff[7];
                        end
                        else
                        begin
                            nxt_sda_oe_n = 1'b1;
                        end
                    end
                end
                CBSC_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_ff == `CBSC_TX_LAST)
                        begin
                            nxt_state = CBSC_RACK;
                            nxt_sda_oe_n = 1'b1;
                        end
                        else
                        begin
                            nxt_cnt = cnt_ff + 4'h1;
                            nxt_tx = {tx_ff[6:0], 1'b0};
                            nxt_sda_oe_n = tx_ff[6];
                        end
                    end
                end
                CBSC_RACK:
                begin
                    // Only one byte is returned whatever the master answers
                    if (scl_fall)
                    begin
                        nxt_state = CBSC_WAIT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_ff <= CBSC_IDLE;
            ack_next_ff <= CBSC_IDLE;
            cnt_ff <= 4'h0;
            rx_ff <= 8'h00;
            tx_ff <= 8'h00;
            offset_ff <= 7'h00;
            cmd_ok_ff <= 1'b0;
            sda_oe_n_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            ack_next_ff <= nxt_ack_next;
            cnt_ff <= nxt_cnt;
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            offset_ff <= nxt_offset;
            cmd_ok_ff <= nxt_cmd_ok;
            sda_oe_n_ff <= nxt_sda_oe_n;
        end
    end

    // Control bytes
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mode_ff <= `CBSC_RST_MODE;
            pair_ff <= `CBSC_RST_PAIR;
            stop_ff <= `CBSC_RST_STOP;
        end
        else if (wr_en)
        begin
            unique case (offset_ff)
                `CBSC_OFS_MODE:
                begin
                    mode_ff <= merge_byte(rx_ff, `CBSC_WMASK_MODE,
                                          `CBSC_RST_MODE);
                end
                `CBSC_OFS_PAIR:
                begin
                    pair_ff <= merge_byte(rx_ff, `CBSC_WMASK_PAIR,
                                          `CBSC_RST_PAIR);
                end
                `CBSC_OFS_STOP:
                begin
                    stop_ff <= merge_byte(rx_ff, `CBSC_WMASK_STOP,
                                          `CBSC_RST_STOP);
                end
                default:
                begin
                    // Writes to other offsets are dropped
                    mode_ff <= mode_ff;
                end
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mode_out_ff <= cbsc_mode_t'(`CBSC_RST_MODE_OUT);
            pair_out_ff <= 4'h0;
            stop_out_ff <= 4'h0;
            sda_out_ff <= 1'b0;
        end
        else
        begin
            mode_out_ff.power_down_tristate <=
                mode_ff[`CBSC_MODE_PD_TRI];
            mode_out_ff.clock_halt_tristate <=
                mode_ff[`CBSC_MODE_HALT_TRI];
            mode_out_ff.bandwidth_select <= mode_ff[`CBSC_MODE_BW];
            mode_out_ff.pll_mode <= mode_ff[`CBSC_MODE_PLL];
            mode_out_ff.half_rate_select_n <= mode_ff[`CBSC_MODE_DIV];
            pair_out_ff <= pair_bits(pair_ff);
            pair_out_ff[`CBSC_IDX_SIX] <= pair_ff[`CBSC_PAIR_SIX]
                                          & pin_sync_ff[1];
            pair_out_ff[`CBSC_IDX_ONE] <= pair_ff[`CBSC_PAIR_ONE]
                                          & pin_sync_ff[0];
            stop_out_ff <= pair_bits(stop_ff);
            sda_out_ff <= 1'b0;
        end
    end

    assign o_mode = mode_out_ff;
    assign o_pair_enable = pair_out_ff;
    assign o_stop_enable = stop_out_ff;
    assign o_sda_out = sda_out_ff;
    assign o_sda_oe_n = sda_oe_n_ff;

endmodule // cbsc_top

// >>> verilog/cbsc_cfg.svh
/*
 * Constants of the clock buffer serial control block: bus address,
 * register offsets, reset values, writable masks, field positions.
 * Assumes it is included once per compile unit through its guard.
 */
`ifndef CBSC_CFG_SVH
`define CBSC_CFG_SVH

`define CBSC_SLAVE_ADDR7 7'h6e
`define CBSC_BIT_LAST 4'h8
`define CBSC_TX_LAST 4'h7
`define CBSC_CMD_BYTE_BIT 7

`define CBSC_OFS_MODE 7'h00
`define CBSC_OFS_PAIR 7'h01
`define CBSC_OFS_STOP 7'h02

`define CBSC_RST_MODE 8'h07
`define CBSC_RST_PAIR 8'hff
`define CBSC_RST_STOP 8'h00
`define CBSC_RST_MODE_OUT 5'h07

`define CBSC_WMASK_MODE 8'hc7
`define CBSC_WMASK_PAIR 8'h66
`define CBSC_WMASK_STOP 8'h66

`define CBSC_MODE_PD_TRI 7
`define CBSC_MODE_HALT_TRI 6
`define CBSC_MODE_BW 2
`define CBSC_MODE_PLL 1
`define CBSC_MODE_DIV 0

`define CBSC_PAIR_SIX 6
`define CBSC_PAIR_FIVE 5
`define CBSC_PAIR_TWO 2
`define CBSC_PAIR_ONE 1

`define CBSC_IDX_SIX 3
`define CBSC_IDX_ONE 0

`endif

// >>> verilog/cbsc_pkg.sv
/*
 * Types of the clock buffer serial control block.
 * Assumes cbsc_cfg.svh supplies all numeric constants but the state encodings.
 */
package cbsc_pkg;

    typedef enum logic [2:0] {
        CBSC_IDLE  = 3'b000,
        CBSC_ADDR  = 3'b001,
        CBSC_CMD   = 3'b010,
        CBSC_WDATA = 3'b011,
        CBSC_ACK   = 3'b100,
        CBSC_RDATA = 3'b101,
        CBSC_RACK  = 3'b110,
        CBSC_WAIT  = 3'b111
    } cbsc_state_t;

    typedef struct packed {
        logic power_down_tristate;
        logic clock_halt_tristate;
        logic bandwidth_select;
        logic pll_mode;
        logic half_rate_select_n;
    } cbsc_mode_t;

endpackage

// >>> test/cbsc_monitor.sv
/*
 * Port checker for cbsc_top: ack timing, output updates, pin gating.
 * Assumes the bind below and the single reference clock domain.
 */
`timescale 1ns/1ps
module cbsc_monitor
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_pair_one_enable,
    input wire logic i_pair_six_enable,
    input wire cbsc_pkg::cbsc_mode_t o_mode,
    input wire logic [3:0] o_pair_enable,
    input wire logic [3:0] o_stop_enable,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n
);
    import cbsc_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    property p_sda_low;
        o_sda_out == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("sda drive level not low");
    property p_reset_vals;
        $rose(i_reset_n) |-> o_mode == 5'h07 && o_stop_enable == 4'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("mode or stop defaults wrong");
    property p_reset_pairs;
        $rose(i_reset_n) && i_pair_one_enable && i_pair_six_enable
            |-> ##[1:4] o_pair_enable == 4'hf;
    endproperty
    a_reset_pairs: assert property (p_reset_pairs)
        else $error("pair enables not all set after reset");
    property p_pin_one;
        !i_pair_one_enable [*4] |-> !o_pair_enable[0];
    endproperty
    a_pin_one: assert property (p_pin_one)
        else $error("pair one enabled with pin low");
    property p_pin_six;
        !i_pair_six_enable [*4] |-> !o_pair_enable[3];
    endproperty
    a_pin_six: assert property (p_pin_six)
        else $error("pair six enabled with pin low");
    property p_mode_quiet;
        $changed(o_mode) |-> !i_scl;
    endproperty
    a_mode_quiet: assert property (p_mode_quiet)
        else $error("mode changed with clock high");
    property p_stop_quiet;
        $changed(o_stop_enable) |-> !i_scl;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("stop enables changed with clock high");
    property p_ack_edge;
        $changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl);
    endproperty
    a_ack_edge: assert property (p_ack_edge)
        else $error("data drive moved near clock high");
    property p_idle_free;
        i_scl [*8] ##1 i_scl [*8] |-> o_sda_oe_n;
    endproperty
    a_idle_free: assert property (p_idle_free)
        else $error("data held low on idle bus");

    c_mode: cover property ($changed(o_mode));
    c_ack: cover property ($fell(o_sda_oe_n));
    c_pin: cover property ($fell(o_pair_enable[0]));
endmodule // cbsc_monitor

bind cbsc_top cbsc_monitor mon_u
(
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_scl(i_scl),
    .i_sda(i_sda), .i_pair_one_enable(i_pair_one_enable),
    .i_pair_six_enable(i_pair_six_enable), .o_mode(o_mode),
    .o_pair_enable(o_pair_enable), .o_stop_enable(o_stop_enable),
    .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n)
);

// >>> test/cbsc_host_model.sv
/*
 * Bus master model issuing byte writes and byte reads.
 * Assumes the bench resolves the pulled-up data wire into i_sda.
 */
`timescale 1ns/1ps
module cbsc_host_model
(
    input wire logic i_ref_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_rel
);
    localparam int HALF = 10;
    initial o_scl = 1'b1;
    initial o_sda_rel = 1'b1;
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Data moves only while the clock is low, after a short hold
    task automatic put_bit(input logic b);
        tick(2);
        o_sda_rel = b;
        tick(HALF - 2);
        o_scl = 1'b1;
        tick(HALF);
        o_scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        tick(2);
        o_sda_rel = 1'b1;
        tick(HALF - 2);
        o_scl = 1'b1;
        tick(HALF - 1);
        b = i_sda;
        tick(1);
        o_scl = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(v[i]);
        get_bit(b);
        ack = ~b;
    endtask
    task automatic start_cond;
        tick(2);
        o_sda_rel = 1'b1;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda_rel = 1'b0;
        tick(HALF);
        o_scl = 1'b0;
    endtask
    task automatic stop_cond;
        tick(2);
        o_sda_rel = 1'b0;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda_rel = 1'b1;
        tick(HALF);
    endtask
    task automatic access(input logic rd, input logic [7:0] adr,
        input logic [7:0] cmd, input logic [7:0] wd,
        output logic [7:0] rdat, output logic [2:0] acks);
        rdat = 8'h00;
        start_cond();
        put_byte(adr, acks[2]);
        put_byte(cmd, acks[1]);
        if (rd)
        begin
            start_cond();
            put_byte(adr | 8'h01, acks[0]);
            for (int i = 7; i >= 0; i--)
                get_bit(rdat[i]);
            put_bit(1'b0);
        end
        else
            put_byte(wd, acks[0]);
        stop_cond();
    endtask
endmodule // cbsc_host_model

// >>> test/clock_buffer_smbus_control_bench.sv
/*
 * Self-checking bench for cbsc_top with a bus master model.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
module clock_buffer_smbus_control_bench;
    import cbsc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic pin_one = 1'b1;
    logic pin_six = 1'b1;
    logic scl;
    logic sda_rel;
    logic sda;
    cbsc_mode_t mode;
    logic [3:0] pair_en;
    logic [3:0] stop_en;
    logic sda_out;
    logic sda_oe_n;
    int n_fail = 0;
    int checks = 0;
    logic [7:0] msk [3] = '{8'hc7, 8'h66, 8'h66};
    logic [7:0] rstv [3] = '{8'h07, 8'hff, 8'h00};
    logic [7:0] exp_reg [3];

    always #50 ref_clk = ~ref_clk;
    // Open-drain data wire with pull-up
    assign sda = sda_rel & (sda_oe_n | sda_out);

    cbsc_top dut_u
    (
        .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_scl(scl),
        .i_sda(sda), .i_pair_one_enable(pin_one),
        .i_pair_six_enable(pin_six), .o_mode(mode),
        .o_pair_enable(pair_en), .o_stop_enable(stop_en),
        .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n)
    );
    cbsc_host_model host_u
    (
        .i_ref_clk(ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic conclude;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] merged(input int o, input logic [7:0] d);
        return (d & msk[o]) | (rstv[o] & ~msk[o]);
    endfunction
    task automatic chk_outs;
        logic [7:0] m;
        logic [7:0] p;
        logic [7:0] s;
        logic [7:0] e;
        m = exp_reg[0];
        p = exp_reg[1];
        s = exp_reg[2];
        e = {3'h0, m[7], m[6], m[2], m[1], m[0]};
        cmp({3'h0, mode}, e);
        e = {4'h0, p[6] & pin_six, p[5], p[2], p[1] & pin_one};
        cmp({4'h0, pair_en}, e);
        cmp({4'h0, stop_en}, {4'h0, s[6], s[5], s[2], s[1]});
    endtask
    task automatic xfer(input logic rd, input logic [7:0] adr,
        input logic [7:0] cmd, input logic [7:0] wd,
        input logic [2:0] eack, output logic [7:0] rdat);
        logic [2:0] acks;
        host_u.access(rd, adr, cmd, wd, rdat, acks);
        cmp({5'h0, acks}, {5'h0, eack});
    endtask
    task automatic wr(input int o, input logic [7:0] d);
        logic [7:0] r;
        xfer(1'b0, 8'hdc, {1'b1, 7'(o)}, d, 3'b111, r);
        if (o < 3)
            exp_reg[o] = merged(o, d);
        chk_outs();
    endtask
    task automatic rd(input int o);
        logic [7:0] r;
        xfer(1'b1, 8'hdc, {1'b1, 7'(o)}, 8'h00, 3'b111, r);
        cmp(r, o < 3 ? exp_reg[o] : 8'h00);
    endtask

    initial
    begin
        repeat (80000) @(posedge ref_clk);
        n_fail++;
        conclude();
    end

    initial
    begin : main
        int o;
        logic [7:0] r;
        o = $urandom(90);
        tick(3);
        reset_n = 1'b1;
        tick(6);
        exp_reg = rstv;
        chk_outs();
        for (int i = 0; i < 4; i++)
            rd(i);
        xfer(1'b0, 8'hde, 8'h80, 8'h00, 3'b000, r);
        xfer(1'b0, 8'hdc, 8'h01, 8'h00, 3'b100, r);
        chk_outs();
        // Read address without a byte command must not be answered
        xfer(1'b1, 8'hdc, 8'h00, 8'h00, 3'b100, r);
        cmp(r, 8'hff);
        wr(3, 8'hff);
        rd(3);
        for (int i = 0; i < 6; i++)
        begin
            wr(i % 3, i < 3 ? 8'hff : 8'h00);
            rd(i % 3);
        end
        for (int i = 0; i < 12; i++)
        begin
            o = $urandom_range(2, 0);
            wr(o, 8'($urandom));
            rd($urandom_range(2, 0));
            pin_one = 1'($urandom);
            pin_six = 1'($urandom);
            tick(6);
            chk_outs();
        end
        pin_one = 1'b1;
        pin_six = 1'b1;
        reset_n = 1'b0;
        tick(3);
        reset_n = 1'b1;
        tick(6);
        exp_reg = rstv;
        chk_outs();
        rd(0);
        conclude();
    end
endmodule // clock_buffer_smbus_control_bench
